// >>> rtl/bicr_pkg.sv
// How it works
// RL1 - command finished without any fault reports the no-error code
// RL2 - command arriving while another is in progress reports busy
// RL3 - reserved or unimplemented vendor command codes report reserved-command
// RL4 - standard codes this responder does not serve report unsupported-command
// RL5 - writes to read-only information commands are refused with access denied
// RL6 - out-of-range values report the overflow/underflow code
// RL7 - transfer of wrong size for the command reports bad size
// RL8 - faults fitting no other class report unknown error
// RL9 - error code sits in low three bits, encoded 0 to 7
// RL10 - code 0x17 reads wear count; threshold at store 0x37-0x38 sets charge per count
// RL11 - every change of wear count is written back to store 0x0c-0x0d
// RL12 - wear count saturates at 65,535
// RL13 - code 0x18 returns nominal capacity, unit chosen by capacity mode bit
// RL14 - code 0x19 returns nominal voltage from store 0x04-0x05
// RL15 - code 0x1a returns specification word from store 0x06-0x07
// RL16 - specification word packs version nibbles, voltage and current exponents
// RL17 - whoever programs the store leaves both exponents at zero
// RL18 - date packs 7-bit year since 1980, 4-bit month, 5-bit day
// RL19 - code 0x1b returns packed date from store 0x08-0x09
// RL20 - code 0x1c returns serial number from store 0x0a-0x0b
// RL21 - code 0x20 returns maker string from store 0x0e-0x19
// RL22 - maker string goes as block read: length byte then up to 11 characters
// RL23 - numeric commands answer low byte first; writes are refused
// RL24 - error field is updated by every command received
package bicr_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WEAR     = 8'h17;
  localparam logic [7:0] CMD_CAP      = 8'h18;
  localparam logic [7:0] CMD_VOLT     = 8'h19;
  localparam logic [7:0] CMD_SPEC     = 8'h1a;
  localparam logic [7:0] CMD_DATE     = 8'h1b;
  localparam logic [7:0] CMD_SERIAL   = 8'h1c;
  localparam logic [7:0] CMD_MAKER    = 8'h20;
  localparam logic [7:0] CMD_STD_LAST = 8'h23;

  // ----------------------------------------------------------------
  // parameter store locations (high byte at the lower address)
  // ----------------------------------------------------------------
  localparam logic [7:0] NV_VOLT    = 8'h04;
  localparam logic [7:0] NV_SPEC    = 8'h06;
  localparam logic [7:0] NV_DATE    = 8'h08;
  localparam logic [7:0] NV_SERIAL  = 8'h0a;
  localparam logic [7:0] NV_WEAR    = 8'h0c;
  localparam logic [7:0] NV_WEAR_LO = 8'h0d;
  localparam logic [7:0] NV_NAME    = 8'h0e;
  localparam logic [7:0] NV_THRESH  = 8'h37;

  // ----------------------------------------------------------------
  // counts and limits
  // ----------------------------------------------------------------
  localparam int unsigned NAME_MAX   = 11;
  localparam logic [3:0]  WORD_BYTES = 4'h2;
  localparam logic [1:0]  BOOT_LAST  = 2'h3;
  localparam logic [15:0] WEAR_SAT   = 16'hffff;
  localparam logic [15:0] WEAR_RST   = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0001;
  localparam logic [3:0]  MONTH_MIN  = 4'h1;
  localparam logic [3:0]  MONTH_MAX  = 4'hc;

  // error field of the status word
  typedef enum logic [2:0] {
    ERR_NONE              = 3'b000,
    ERR_BUSY              = 3'b001,
    ERR_RESERVED_CMD      = 3'b010,
    ERR_UNIMPLEMENTED_CMD = 3'b011,
    ERR_WRITE_REFUSED     = 3'b100,
    ERR_OVERFLOW          = 3'b101,
    ERR_WRONG_LENGTH      = 3'b110,
    ERR_UNCLASSIFIED      = 3'b111
  } bicr_err_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       blk;
    logic [7:0] code;
  } bicr_req_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } bicr_rsp_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
  } bicr_nv_rd_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } bicr_nv_wr_t;

  typedef struct packed {
    logic [3:0] current_exponent;
    logic [3:0] voltage_exponent;
    logic [3:0] version_high_nibble;
    logic [3:0] version_low_nibble;
  } bicr_spec_t;

  typedef struct packed {
    logic [6:0] year_since_base;
    logic [3:0] month;
    logic [4:0] day;
  } bicr_date_t;

endpackage : bicr_pkg

// >>> rtl/bicr_wear_ctr.sv
module bicr_wear_ctr (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // start-up load from the parameter store
  input  wire logic        load_i,
  input  wire logic [15:0] count_ld_i,
  input  wire logic [15:0] thresh_ld_i,
  // charge events and write-back handshake
  input  wire logic        tick_i,
  input  wire logic        wb_take_i,
  output logic [15:0]      count_o,
  output logic             sat_o,
  output logic             wb_pend_o
);

  logic [15:0] acc_q;
  logic [15:0] thresh_q;
  logic [15:0] count_q;
  logic        pend_q;

  // ----------------------------------------------------------------
  // threshold decode
  // ----------------------------------------------------------------
  wire [15:0] thr_eff = (thresh_q == bicr_pkg::WEAR_RST) ? bicr_pkg::THRESH_RST : thresh_q;
  wire        roll    = tick_i && (acc_q >= 16'(thr_eff - bicr_pkg::THRESH_RST)); // RL10
  wire        bump    = roll && (count_q != bicr_pkg::WEAR_SAT);                // RL12

  // charge accumulator and wear count
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      acc_q    <= bicr_pkg::WEAR_RST;
      thresh_q <= bicr_pkg::THRESH_RST;
      count_q  <= bicr_pkg::WEAR_RST;
    end
    else if (ce_i)
    begin
      if (load_i)
      begin
        acc_q    <= bicr_pkg::WEAR_RST;
        thresh_q <= thresh_ld_i;
        count_q  <= count_ld_i;
      end
      else if (tick_i)
      begin
        acc_q <= roll ? bicr_pkg::WEAR_RST : 16'(acc_q + 16'h0001);
        if (bump)
          count_q <= 16'(count_q + 16'h0001);
      end
    end
  end

  // write-back request; a new change wins over the take
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pend_q <= 1'b0;
    else if (ce_i)
      pend_q <= (bump && !load_i) ? 1'b1 : (wb_take_i ? 1'b0 : pend_q); // RL11
  end

  assign count_o   = count_q;
  assign sat_o     = (count_q == bicr_pkg::WEAR_SAT);
  assign wb_pend_o = pend_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wear_sat_hold: assert property (@(posedge clk_i) disable iff (srst_i) // RL12
    ce_i && !load_i && count_q == bicr_pkg::WEAR_SAT |=> count_q == bicr_pkg::WEAR_SAT)
    else $error("wear count left saturation");
  a_wear_step: assert property (@(posedge clk_i) disable iff (srst_i) // RL10
    ce_i && !load_i && bump |=> count_q == 16'($past(count_q) + 16'h0001) && pend_q)
    else $error("wear count step or write-back request missing");

endmodule : bicr_wear_ctr

// >>> rtl/bicr_responder.sv
module bicr_responder #(
  parameter int unsigned MAX_CHARS = bicr_pkg::NAME_MAX
) (
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  // command request from the smbus protocol layer
  input  wire logic                 req_valid_i,
  input  wire bicr_pkg::bicr_req_t  req_i,
  // answer bytes and command result
  output bicr_pkg::bicr_rsp_t       rsp_o,
  input  wire logic                 rsp_ready_i,
  output logic                      done_o,
  output bicr_pkg::bicr_err_t       err_code_o,
  // gauge side
  input  wire logic                 charge_tick_i,
  input  wire logic                 cap_mode_i,
  input  wire logic [15:0]          cap_mah_i,
  input  wire logic [15:0]          cap_10mwh_i,
  // nonvolatile parameter store
  output bicr_pkg::bicr_nv_rd_t     nv_rd_o,
  input  wire logic [7:0]           nv_rdata_i,
  input  wire logic                 nv_fault_i,
  output bicr_pkg::bicr_nv_wr_t     nv_wr_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (MAX_CHARS < 1 || MAX_CHARS > bicr_pkg::NAME_MAX)
  begin : g_bad_chars
    $error("MAX_CHARS out of range");
  end

  localparam logic [7:0] MAX_B = 8'(MAX_CHARS);

  typedef enum logic [2:0] {
    S_BOOT = 3'b000,
    S_RD   = 3'b001,
    S_CAP  = 3'b010,
    S_IDLE = 3'b011,
    S_SEND = 3'b100,
    S_WB   = 3'b101
  } bicr_state_t;

  bicr_state_t           state_q;
  bicr_state_t           state_d;
  logic                  booting_q;
  logic [3:0]            idx_q;
  logic [3:0]            n_q;
  logic [7:0]            cmd_q;
  logic                  fault_q;
  logic [15:0]           word_q;
  logic [31:0]           boot_buf_q;
  logic                  load_q;
  logic [15:0]           wb_val_q;
  logic                  wb_hi_q;
  bicr_pkg::bicr_rsp_t   rsp_q;
  logic                  done_q;
  bicr_pkg::bicr_err_t   err_q;
  bicr_pkg::bicr_nv_rd_t nv_rd_q;
  bicr_pkg::bicr_nv_wr_t nv_wr_q;
  logic [15:0]           wear_count;
  logic                  wear_sat;
  logic                  wb_pend;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);

  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  wire       idle     = (state_q == S_IDLE);
  wire       req_in   = ce_i && req_valid_i;
  wire [7:0] code     = idle ? req_i.code : cmd_q;
  wire       is_str   = (code == bicr_pkg::CMD_MAKER);
  wire       is_loc   = (code == bicr_pkg::CMD_WEAR) || (code == bicr_pkg::CMD_CAP);
  wire       is_ours  = is_loc || is_str || (code == bicr_pkg::CMD_VOLT)
                     || (code == bicr_pkg::CMD_SPEC) || (code == bicr_pkg::CMD_DATE)
                     || (code == bicr_pkg::CMD_SERIAL);
  wire       is_std   = (code <= bicr_pkg::CMD_STD_LAST);
  wire       busy_hit = req_in && !idle;                                      // RL2
  bicr_pkg::bicr_err_t req_err;
  assign req_err = !is_ours ? (is_std ? bicr_pkg::ERR_UNIMPLEMENTED_CMD      // RL4
                                      : bicr_pkg::ERR_RESERVED_CMD)          // RL3
                 : req_i.wr ? bicr_pkg::ERR_WRITE_REFUSED                    // RL5 RL23
                 : (req_i.blk != is_str) ? bicr_pkg::ERR_WRONG_LENGTH        // RL7
                 : bicr_pkg::ERR_NONE;
  wire start = req_in && idle && (req_err == bicr_pkg::ERR_NONE);

  // ----------------------------------------------------------------
  // byte addressing and answer sources
  // ----------------------------------------------------------------
  wire [3:0] nxt_idx = idle ? 4'h0 : 4'(idx_q + 4'h1);
  wire [7:0] base    = (code == bicr_pkg::CMD_VOLT)   ? bicr_pkg::NV_VOLT      // RL14
                     : (code == bicr_pkg::CMD_SPEC)   ? bicr_pkg::NV_SPEC      // RL15
                     : (code == bicr_pkg::CMD_DATE)   ? bicr_pkg::NV_DATE      // RL19
                     : (code == bicr_pkg::CMD_SERIAL) ? bicr_pkg::NV_SERIAL    // RL20
                     : bicr_pkg::NV_NAME;                                      // RL21
  // low byte at the odd location goes first
  wire [3:0] offs    = is_str ? nxt_idx : {3'b000, ~nxt_idx[0]};               // RL23
  wire [7:0] rd_addr = 8'(base + {4'h0, offs});
  wire [7:0] boot_addr = 8'((idx_q[1] ? bicr_pkg::NV_THRESH : bicr_pkg::NV_WEAR)
                         + {7'h00, idx_q[0]});
  wire [15:0] loc_word = (code == bicr_pkg::CMD_WEAR) ? wear_count             // RL10
                       : (cap_mode_i ? cap_10mwh_i : cap_mah_i);               // RL13
  wire [7:0] loc_byte = nxt_idx[0] ? loc_word[15:8] : loc_word[7:0];
  wire       loc_last = (nxt_idx == 4'h1);

  // length byte clipped to the string limit
  wire [7:0] len_clip = (nv_rdata_i > MAX_B) ? MAX_B : nv_rdata_i;             // RL22
  wire       len_slot = is_str && (idx_q == 4'h0);
  wire [7:0] cap_byte = len_slot ? len_clip : nv_rdata_i;
  wire [3:0] n_eff    = len_slot ? 4'(len_clip[3:0] + 4'h1) : n_q;
  wire       cap_last = (idx_q == 4'(n_eff - 4'h1));
  wire       sent     = ce_i && (state_q == S_SEND) && rsp_ready_i;
  wire       finish   = sent && rsp_q.last;

  // ----------------------------------------------------------------
  // value checks at the end of a command
  // ----------------------------------------------------------------
  bicr_pkg::bicr_date_t date_v;
  bicr_pkg::bicr_spec_t spec_v;
  assign date_v = word_q;                                                      // RL18
  assign spec_v = word_q;                                                      // RL16
  wire date_bad = (cmd_q == bicr_pkg::CMD_DATE)
               && (date_v.month < bicr_pkg::MONTH_MIN || date_v.month > bicr_pkg::MONTH_MAX);
  wire spec_bad = (cmd_q == bicr_pkg::CMD_SPEC)
               && (spec_v.voltage_exponent != 4'h0 || spec_v.current_exponent != 4'h0);
  wire ovf      = ((cmd_q == bicr_pkg::CMD_WEAR) && wear_sat) || date_bad || spec_bad;
  bicr_pkg::bicr_err_t fin_err;
  assign fin_err = fault_q ? bicr_pkg::ERR_UNCLASSIFIED                        // RL8
                 : ovf ? bicr_pkg::ERR_OVERFLOW                                // RL6
                 : bicr_pkg::ERR_NONE;                                         // RL1
  wire wb_take = ce_i && idle && !req_valid_i && wb_pend;                     // RL11

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_BOOT: state_d = S_RD;
      S_RD:   state_d = S_CAP;
      S_CAP:
      begin
        if (!booting_q)
          state_d = S_SEND;
        else if (idx_q[1:0] == bicr_pkg::BOOT_LAST)
          state_d = S_IDLE;
        else
          state_d = S_BOOT;
      end
      S_IDLE:
      begin
        if (start)
          state_d = is_loc ? S_SEND : S_RD;
        else if (wb_take)
          state_d = S_WB;
      end
      S_SEND:
      begin
        if (rsp_ready_i)
          state_d = rsp_q.last ? S_IDLE : (is_loc ? S_SEND : S_RD);
      end
      S_WB:   state_d = wb_hi_q ? S_WB : S_IDLE;
      default: state_d = S_BOOT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_q <= S_BOOT;
    else if (ce_i)
      state_q <= state_d;
  end

  // byte index, length and command capture
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      idx_q     <= 4'h0;
      n_q       <= 4'h0;
      cmd_q     <= 8'h00;
      booting_q <= 1'b1;
    end
    else if (ce_i)
    begin
      if (start)
      begin
        cmd_q <= req_i.code;
        idx_q <= 4'h0;
        n_q   <= bicr_pkg::WORD_BYTES;
      end
      else if (state_q == S_CAP && booting_q)
      begin
        idx_q     <= 4'(idx_q + 4'h1);
        booting_q <= (idx_q[1:0] != bicr_pkg::BOOT_LAST);
      end
      else if (state_q == S_CAP)
        n_q <= n_eff;
      else if (sent)
        idx_q <= nxt_idx;
    end
  end

  // fetched data, fault flag and start-up words
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fault_q    <= 1'b0;
      word_q     <= 16'h0000;
      boot_buf_q <= 32'h0000_0000;
      load_q     <= 1'b0;
    end
    else if (ce_i)
    begin
      load_q <= (state_q == S_CAP) && booting_q && (idx_q[1:0] == bicr_pkg::BOOT_LAST);
      if (start)
      begin
        fault_q <= 1'b0;
        word_q  <= 16'h0000;
      end
      else if (state_q == S_CAP && booting_q)
        boot_buf_q <= {boot_buf_q[23:0], nv_rdata_i};
      else if (state_q == S_CAP)
      begin
        fault_q <= fault_q || nv_fault_i;                                      // RL8
        if (idx_q[0])
          word_q[15:8] <= nv_rdata_i;
        else
          word_q[7:0] <= nv_rdata_i;
      end
    end
  end

  // answer byte register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rsp_q <= '0;
    else if (ce_i)
    begin
      if ((start || (sent && !rsp_q.last)) && is_loc)
        rsp_q <= '{valid: 1'b1, last: loc_last, data: loc_byte};               // RL23
      else if (state_q == S_CAP && !booting_q)
        rsp_q <= '{valid: 1'b1, last: cap_last, data: cap_byte};               // RL22
      else if (sent)
        rsp_q <= '0;
    end
  end

  // result of every command, busy taking precedence
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      done_q <= 1'b0;
      err_q  <= bicr_pkg::ERR_NONE;
    end
    else if (ce_i)
    begin
      done_q <= busy_hit || finish || (req_in && idle && !start);            // RL24
      if (busy_hit)
        err_q <= bicr_pkg::ERR_BUSY;                                           // RL2
      else if (finish)
        err_q <= fin_err;                                                      // RL1
      else if (req_in && idle && !start)
        err_q <= req_err;                                                      // RL24
    end
  end

  // parameter store read strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      nv_rd_q <= '0;
    else if (ce_i)
    begin
      if (state_q == S_BOOT)
        nv_rd_q <= '{en: 1'b1, addr: boot_addr};
      else if ((start || (sent && !rsp_q.last)) && !is_loc)
        nv_rd_q <= '{en: 1'b1, addr: rd_addr};
      else
        nv_rd_q.en <= 1'b0;
    end
  end

  // wear count write-back, high byte then low byte
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      nv_wr_q  <= '0;
      wb_val_q <= 16'h0000;
      wb_hi_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wb_take)
      begin
        nv_wr_q  <= '{en: 1'b1, addr: bicr_pkg::NV_WEAR, data: wear_count[15:8]}; // RL11
        wb_val_q <= wear_count;
        wb_hi_q  <= 1'b1;
      end
      else if (state_q == S_WB && wb_hi_q)
      begin
        nv_wr_q <= '{en: 1'b1, addr: bicr_pkg::NV_WEAR_LO, data: wb_val_q[7:0]};  // RL11
        wb_hi_q <= 1'b0;
      end
      else
        nv_wr_q.en <= 1'b0;
    end
  end

  bicr_wear_ctr u_wear (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .load_i      (load_q),
    .count_ld_i  (boot_buf_q[31:16]),
    .thresh_ld_i (boot_buf_q[15:0]),
    .tick_i      (charge_tick_i),
    .wb_take_i   (wb_take),
    .count_o     (wear_count),
    .sat_o       (wear_sat),
    .wb_pend_o   (wb_pend)
  );

  assign rsp_o      = rsp_q;
  assign done_o     = done_q;
  assign err_code_o = err_q;                                                   // RL9
  assign nv_rd_o    = nv_rd_q;
  assign nv_wr_o    = nv_wr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wb_hi;
    nv_wr_o.en && nv_wr_o.addr == bicr_pkg::NV_WEAR;
  endsequence
  sequence s_wb_lo;
    nv_wr_o.en && nv_wr_o.addr == bicr_pkg::NV_WEAR_LO && nv_wr_o.data == wb_val_q[7:0];
  endsequence

  a_ok_code: assert property (finish && !fault_q && !ovf && !busy_hit // RL1
    |=> done_q && err_q == bicr_pkg::ERR_NONE) else $error("no-error code missing");
  a_busy_code: assert property (busy_hit // RL2
    |=> done_q && err_q == bicr_pkg::ERR_BUSY) else $error("busy code missing");
  a_rsvd_code: assert property (req_in && idle && !is_std // RL3
    |=> err_q == bicr_pkg::ERR_RESERVED_CMD) else $error("reserved code missing");
  a_unimpl_code: assert property (req_in && idle && is_std && !is_ours // RL4
    |=> err_q == bicr_pkg::ERR_UNIMPLEMENTED_CMD) else $error("unsupported code missing");
  a_write_refused: assert property (req_in && idle && is_ours && req_i.wr // RL5
    |=> err_q == bicr_pkg::ERR_WRITE_REFUSED && !rsp_o.valid && !nv_rd_o.en)
    else $error("write to read-only command not refused");
  a_ovf_code: assert property (finish && !fault_q && ovf && !busy_hit // RL6
    |=> err_q == bicr_pkg::ERR_OVERFLOW) else $error("overflow code missing");
  a_wrong_len: assert property (req_in && idle && is_ours && !req_i.wr // RL7
    && req_i.blk != is_str |=> err_q == bicr_pkg::ERR_WRONG_LENGTH)
    else $error("bad size code missing");
  a_fault_code: assert property (finish && fault_q && !busy_hit // RL8
    |=> err_q == bicr_pkg::ERR_UNCLASSIFIED) else $error("unknown error code missing");
  a_wear_answer: assert property (start && code == bicr_pkg::CMD_WEAR // RL10
    |=> rsp_o.valid && !rsp_o.last && rsp_o.data == $past(wear_count[7:0]))
    else $error("wear count low byte not first");
  a_wb_pair: assert property (s_wb_hi |=> s_wb_lo ##1 !nv_wr_o.en) // RL11
    else $error("write-back pair broken");
  a_name_len: assert property (rsp_o.valid && cmd_q == bicr_pkg::CMD_MAKER // RL22
    && idx_q == 4'h0 |-> rsp_o.data <= MAX_B) else $error("string length above limit");

endmodule : bicr_responder

// >>> verification/bicr_nv_model.sv
module bicr_nv_model (
  // clock
  input  wire logic                  clk_i,
  // store port of the responder
  input  wire bicr_pkg::bicr_nv_rd_t rd_i,
  input  wire bicr_pkg::bicr_nv_wr_t wr_i,
  output logic [7:0]                 rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];

  // contents: name chars equal their address
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    {mem[8'h04], mem[8'h05]} = 16'h2a30;
    {mem[8'h06], mem[8'h07]} = 16'h0031;
    {mem[8'h08], mem[8'h09]} = 16'h2c4f;
    {mem[8'h0a], mem[8'h0b]} = 16'h0001;
    {mem[8'h0c], mem[8'h0d]} = 16'h0000;
    mem[8'h0e] = 8'h0c;
    {mem[8'h37], mem[8'h38]} = 16'h0001;
  end

  // byte one cycle after the strobe, garbage otherwise
  always @(posedge clk_i)
  begin
    if (wr_i.en) mem[wr_i.addr] <= wr_i.data;
    rdata_o <= rd_i.en ? mem[rd_i.addr] : ~rdata_o;
  end
endmodule : bicr_nv_model

// >>> verification/tb_battery_info_command_responder.sv
module tb_battery_info_command_responder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, srst_i = 1, ce_i = 1, req_valid_i = 0, rsp_ready_i = 0;
  logic charge_tick_i = 0, cap_mode_i = 0, nv_fault_i = 0;
  logic [15:0] cap_mah_i = 16'h0000, cap_10mwh_i = 16'h0000;
  logic [7:0]  nv_rdata_i;
  logic [31:0] seed = 32'h31;
  bicr_pkg::bicr_req_t   req_i = '0;
  bicr_pkg::bicr_rsp_t   rsp_o;
  bicr_pkg::bicr_err_t   err_code_o;
  bicr_pkg::bicr_nv_rd_t nv_rd_o;
  bicr_pkg::bicr_nv_wr_t nv_wr_o;
  logic done_o;
  logic [7:0] qb [$];
  logic [2:0] qe [$];
  int bad_count = 0, n_tests = 0;

  bicr_responder u_dut (.clk_i, .srst_i, .ce_i, .req_valid_i, .req_i, .rsp_o, .rsp_ready_i,
    .done_o, .err_code_o, .charge_tick_i, .cap_mode_i, .cap_mah_i, .cap_10mwh_i,
    .nv_rd_o, .nv_rdata_i, .nv_fault_i, .nv_wr_o);
  bicr_nv_model u_nv (.clk_i, .rd_i(nv_rd_o), .wr_i(nv_wr_o), .rdata_o(nv_rdata_i));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // one command, then wait for its result
  task automatic req(input logic w, input logic b, input logic [7:0] c, input logic [2:0] e);
    int k;
    qe.push_back(e);
    req_valid_i = 1;
    req_i = '{w, b, c};
    @(posedge clk_i) #1;
    req_valid_i = 0;
    for (k = 0; k < 300 && done_o !== 1'b1; k++) @(posedge clk_i) #1;
    if (k == 300) check(8'h01, 8'h00);
    @(posedge clk_i) #1;
  endtask : req

  task automatic wrd(input logic [7:0] c, input logic [15:0] v, input logic [2:0] e);
    qb.push_back(v[7:0]);
    qb.push_back(v[15:8]);
    req(0, 0, c, e);
  endtask : wrd

  // consumer stalls at random
  always @(posedge clk_i)
  begin
    seed <= xs(seed);
    rsp_ready_i <= #1 seed[3];
  end

  // compare answer bytes and results against the notes
  always @(posedge clk_i)
  begin
    if (!srst_i && rsp_o.valid && rsp_ready_i) check(rsp_o.data, qb.pop_front());
    if (!srst_i && done_o) check(8'(err_code_o), 8'(qe.pop_front()));
  end

  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 srst_i = 0;
    req(0, 0, bicr_pkg::CMD_VOLT, 3'h1);
    repeat (20) @(posedge clk_i) #1;
    repeat (3)
    begin
      charge_tick_i = 1;
      @(posedge clk_i) #1 charge_tick_i = 0;
      repeat (5) @(posedge clk_i) #1;
    end
    // enable low: a held tick must not move the count
    ce_i = 0;
    charge_tick_i = 1;
    repeat (4) @(posedge clk_i) #1;
    ce_i = 1;
    charge_tick_i = 0;
    repeat (4) @(posedge clk_i) #1;
    check(u_nv.mem[8'h0c], 8'h00);
    check(u_nv.mem[8'h0d], 8'h03);
    wrd(bicr_pkg::CMD_WEAR, 16'h0003, 3'h0);
    for (int m = 0; m < 2; m++)
    begin
      cap_mah_i = seed[15:0];
      cap_10mwh_i = seed[31:16];
      cap_mode_i = m[0];
      wrd(bicr_pkg::CMD_CAP, m ? cap_10mwh_i : cap_mah_i, 3'h0);
    end
    wrd(bicr_pkg::CMD_VOLT, 16'h2a30, 3'h0);
    wrd(bicr_pkg::CMD_SPEC, 16'h0031, 3'h0);
    wrd(bicr_pkg::CMD_DATE, 16'h2c4f, 3'h0);
    wrd(bicr_pkg::CMD_SERIAL, 16'h0001, 3'h0);
    // store fault on every byte of one command
    nv_fault_i = 1;
    wrd(bicr_pkg::CMD_SERIAL, 16'h0001, 3'h7);
    nv_fault_i = 0;
    qb.push_back(8'h0b);
    for (int i = 8'h0f; i < 8'h1a; i++) qb.push_back(8'(i));
    req(0, 1, bicr_pkg::CMD_MAKER, 3'h0);
    req(1, 0, bicr_pkg::CMD_VOLT, 3'h4);
    req(1, 0, bicr_pkg::CMD_WEAR, 3'h4);
    req(0, 1, bicr_pkg::CMD_VOLT, 3'h6);
    req(0, 0, bicr_pkg::CMD_MAKER, 3'h6);
    req(0, 0, 8'h21, 3'h3);
    req(0, 0, 8'h30, 3'h2);
    u_nv.mem[8'h06] = 8'h01;
    wrd(bicr_pkg::CMD_SPEC, 16'h0131, 3'h5);
    check(8'(qb.size()), 8'h00);
    check(8'(qe.size()), 8'h00);
    complete_run();
  end
endmodule : tb_battery_info_command_responder
